// file: rtl/cpu_regs_pkg.sv
package cpu_regs_pkg;

    // Register word offsets on the 32-bit bus (byte addresses)
    localparam logic [7:0] OFS_PROGRAM_COUNTER = 8'h00;
    localparam logic [7:0] OFS_ACCUMULATOR = 8'h04;
    localparam logic [7:0] OFS_TEMPORARY_ACCUMULATOR = 8'h08;
    localparam logic [7:0] OFS_INDEX_POINTER = 8'h0C;
    localparam logic [7:0] OFS_EXTRA_POINTER = 8'h10;
    localparam logic [7:0] OFS_STACK_POINTER = 8'h14;
    localparam logic [7:0] OFS_PROGRAM_STATUS_WORD = 8'h18;
    localparam logic [7:0] OFS_ALU_COMMAND = 8'h1C;
    localparam logic [7:0] OFS_CORE_STATUS = 8'h20;
    localparam logic [7:0] OFS_BANK_ADDRESS = 8'h24;

    // Reset values
    localparam logic [15:0] RST_PROGRAM_COUNTER = 16'hFFFD;
    localparam logic [1:0] RST_INTERRUPT_LEVEL_MASK = 2'h3;
    localparam logic RST_INTERRUPT_ENABLE = 1'b0;

    // Condition code byte positions
    localparam int CC_HALF_CARRY = 7;
    localparam int CC_INT_ENABLE = 6;
    localparam int CC_LEVEL_HI = 5;
    localparam int CC_LEVEL_LO = 4;
    localparam int CC_NEGATIVE = 3;
    localparam int CC_ZERO = 2;
    localparam int CC_OVERFLOW = 1;
    localparam int CC_CARRY = 0;

    // Memory map of the 64 Kbyte space
    localparam logic [15:0] MAP_IO_BASE = 16'h0000;
    localparam logic [15:0] MAP_IO_LAST = 16'h007F;
    localparam logic [15:0] MAP_DATA_BASE = 16'h0080;
    localparam logic [15:0] MAP_VECTOR_BASE = 16'hFFC0;
    localparam logic [15:0] MAP_REGISTER_BASE = 16'h0100;
    localparam logic [15:0] MAP_PROGRAM_BASE = 16'hC000;

    // Bank geometry
    localparam int REGS_PER_BANK = 8;

    typedef enum logic [1:0] {
        REGION_IO = 2'h0,
        REGION_DATA = 2'h1,
        REGION_PROGRAM = 2'h3,
        REGION_VECTOR = 2'h2
    } region_e;

    typedef enum logic [2:0] {
        ALU_ADD = 3'h0,
        ALU_SUB = 3'h1,
        ALU_ADDC = 3'h2,
        ALU_SUBC = 3'h3,
        ALU_SHL = 3'h4,
        ALU_SHR = 3'h5
    } alu_op_e;

    typedef struct packed {
        logic half;
        logic negative;
        logic zero;
        logic overflow;
        logic carry;
    } flags_s;

    typedef struct packed {
        logic request;
        logic [1:0] level;
    } irq_req_s;

endpackage : cpu_regs_pkg

// file: rtl/cpu_register_set.sv
// Overview of operation
// - One 64 Kbyte space, I/O at bottom
// - Data above I/O, program and vectors top
// - 16-bit program counter, resets to FFFD
// - 16-bit accumulator, 8-bit ops use low byte
// - 16-bit temporary accumulator, second operand
// - Index, extra and stack pointers, 16 bits
// - Status word: bank pointer high, flags low
// - Reset: level mask 11, enable cleared
// - Interrupts accepted only when enable set
// - Request level must beat the level mask
// - Half carry from bit 3 to bit 4
// - Negative follows result MSB
// - Zero set on zero result
// - Overflow on two's complement overflow
// - Carry or borrow out of bit 7
// - Shifts put shifted-out bit in carry
// - Banks of eight 8-bit registers in memory
// - Bank count is a build parameter
// - Bank pointer selects active bank address
//
// Added by the designer: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module cpu_register_set
    import cpu_regs_pkg::*;
#(
    parameter int BANK_COUNT = 32
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Core side
    input wire logic instrFetch,
    input wire irq_req_s irqIn,
    output logic irqAccept,
    output logic [15:0] bankAddress
);

    localparam int BANK_BITS = $clog2(BANK_COUNT);

    // Dedicated registers; data registers carry no reset
    logic [15:0] programCounter;
    logic [15:0] accumulator;
    logic [15:0] temporaryAccumulator;
    logic [15:0] indexPointer;
    logic [15:0] extraPointer;
    logic [15:0] stackPointer;
    logic [7:0] bankPointer;
    logic [7:0] conditionCodeByte;
    logic aluGo;
    alu_op_e aluOp;

    // Bus decode
    wire logic busReq = wb_cyc_i & wb_stb_i;
    wire logic busWrite = busReq & wb_we_i & wb_ack_o;
    wire logic hitPc = (wb_adr_i == OFS_PROGRAM_COUNTER);
    wire logic hitAcc = (wb_adr_i == OFS_ACCUMULATOR);
    wire logic hitTmp = (wb_adr_i == OFS_TEMPORARY_ACCUMULATOR);
    wire logic hitIdx = (wb_adr_i == OFS_INDEX_POINTER);
    wire logic hitExt = (wb_adr_i == OFS_EXTRA_POINTER);
    wire logic hitStk = (wb_adr_i == OFS_STACK_POINTER);
    wire logic hitPsw = (wb_adr_i == OFS_PROGRAM_STATUS_WORD);
    wire logic hitAlu = (wb_adr_i == OFS_ALU_COMMAND);
    wire logic hitSts = (wb_adr_i == OFS_CORE_STATUS);
    wire logic hitBank = (wb_adr_i == OFS_BANK_ADDRESS);
    wire logic pswLowWrite = busWrite & hitPsw & wb_sel_i[0];

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] sel);
        logic [15:0] r;
        r = old;
        if (sel[0]) begin
            r[7:0] = d[7:0];
        end
        if (sel[1]) begin
            r[15:8] = d[15:8];
        end
        return r;
    endfunction : merge16

    // Memory region of the program counter
    function automatic region_e regionOf(input logic [15:0] adr);
        if (adr <= MAP_IO_LAST) begin
            return REGION_IO;
        end else if (adr >= MAP_VECTOR_BASE) begin
            return REGION_VECTOR;
        end else if (adr >= MAP_PROGRAM_BASE) begin
            return REGION_PROGRAM;
        end else begin
            return REGION_DATA;
        end
    endfunction : regionOf

    wire region_e pcRegion = regionOf(programCounter);

    // 8-bit arithmetic on the low bytes of both accumulators
    wire logic [7:0] lhs = accumulator[7:0];
    wire logic [7:0] rhs = temporaryAccumulator[7:0];
    wire logic carryIn = conditionCodeByte[CC_CARRY];
    wire logic useCarry = (aluOp == ALU_ADDC) || (aluOp == ALU_SUBC);
    wire logic isSub = (aluOp == ALU_SUB) || (aluOp == ALU_SUBC);
    wire logic isShift = (aluOp == ALU_SHL) || (aluOp == ALU_SHR);
    wire logic cin = useCarry & carryIn;
    wire logic [8:0] addFull = {1'b0, lhs} + {1'b0, rhs} + {8'h00, cin};
    wire logic [8:0] subFull = {1'b0, lhs} - {1'b0, rhs} - {8'h00, cin};
    wire logic [4:0] addNib = {1'b0, lhs[3:0]} + {1'b0, rhs[3:0]} + {4'h0, cin};
    wire logic [4:0] subNib = {1'b0, lhs[3:0]} - {1'b0, rhs[3:0]} - {4'h0, cin};
    wire logic [8:0] arith = isSub ? subFull : addFull;
    wire logic [7:0] shiftRes = (aluOp == ALU_SHL) ? {lhs[6:0], carryIn} : {carryIn, lhs[7:1]};
    wire logic shiftOut = (aluOp == ALU_SHL) ? lhs[7] : lhs[0];
    wire logic [7:0] aluRes = isShift ? shiftRes : arith[7:0];
    wire logic addOvf = (lhs[7] == rhs[7]) && (arith[7] != lhs[7]);
    wire logic subOvf = (lhs[7] != rhs[7]) && (arith[7] != lhs[7]);

    flags_s aluFlags;
    always_comb begin
        aluFlags.half = isSub ? subNib[4] : addNib[4];
        aluFlags.negative = aluRes[7];
        aluFlags.zero = (aluRes == 8'h00);
        aluFlags.overflow = isSub ? subOvf : addOvf;
        aluFlags.carry = isShift ? shiftOut : arith[8];
        if (isShift) begin
            aluFlags.half = conditionCodeByte[CC_HALF_CARRY];
            aluFlags.overflow = conditionCodeByte[CC_OVERFLOW];
        end
    end

    // Interrupt acceptance: smaller code is a higher level
    wire logic [1:0] levelMask = conditionCodeByte[CC_LEVEL_HI:CC_LEVEL_LO];
    wire logic levelOk = (irqIn.level < levelMask);
    wire logic next_irqAccept = irqIn.request & conditionCodeByte[CC_INT_ENABLE] & levelOk;

    // Bank base; pointer bits above the bank count are dropped
    wire logic [BANK_BITS-1:0] bankSel = bankPointer[BANK_BITS-1:0];
    wire logic [15:0] next_bankAddress =
        MAP_REGISTER_BASE + 16'(REGS_PER_BANK * int'(bankSel));

    // Read mux
    logic [31:0] readData;
    always_comb begin
        readData = 32'h0000_0000;
        if (hitPc) begin
            readData[15:0] = programCounter;
        end else if (hitAcc) begin
            readData[15:0] = accumulator;
        end else if (hitTmp) begin
            readData[15:0] = temporaryAccumulator;
        end else if (hitIdx) begin
            readData[15:0] = indexPointer;
        end else if (hitExt) begin
            readData[15:0] = extraPointer;
        end else if (hitStk) begin
            readData[15:0] = stackPointer;
        end else if (hitPsw) begin
            readData[15:0] = {bankPointer, conditionCodeByte};
        end else if (hitAlu) begin
            readData[2:0] = aluOp;
        end else if (hitSts) begin
            readData[3:0] = {aluGo, irqAccept, pcRegion};
        end else if (hitBank) begin
            readData[15:0] = bankAddress;
        end
    end

    // Bus handshake: ack one cycle after the request, dropped next cycle
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= busReq & ~wb_ack_o;
            wb_dat_o <= readData;
        end
    end

    // Program counter
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            programCounter <= RST_PROGRAM_COUNTER;
        end else if (busWrite && hitPc) begin
            programCounter <= merge16(programCounter, wb_dat_i, wb_sel_i);
        end else if (instrFetch) begin
            programCounter <= programCounter + 16'h0001;
        end
    end

    // Working and pointer registers: undefined after reset
    always_ff @(posedge clock) begin
        if (aluGo) begin
            accumulator[7:0] <= aluRes;
        end else if (busWrite && hitAcc) begin
            accumulator <= merge16(accumulator, wb_dat_i, wb_sel_i);
        end
        if (busWrite && hitTmp) begin
            temporaryAccumulator <= merge16(temporaryAccumulator, wb_dat_i, wb_sel_i);
        end
        if (busWrite && hitIdx) begin
            indexPointer <= merge16(indexPointer, wb_dat_i, wb_sel_i);
        end
        if (busWrite && hitExt) begin
            extraPointer <= merge16(extraPointer, wb_dat_i, wb_sel_i);
        end
        if (busWrite && hitStk) begin
            stackPointer <= merge16(stackPointer, wb_dat_i, wb_sel_i);
        end
        if (busWrite && hitPsw && wb_sel_i[1]) begin
            bankPointer <= wb_dat_i[15:8];
        end
    end

    // Condition code byte: only enable and level carry a reset value
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            conditionCodeByte[CC_INT_ENABLE] <= RST_INTERRUPT_ENABLE;
            conditionCodeByte[CC_LEVEL_HI:CC_LEVEL_LO] <= RST_INTERRUPT_LEVEL_MASK;
        end else if (pswLowWrite) begin
            conditionCodeByte[CC_INT_ENABLE] <= wb_dat_i[CC_INT_ENABLE];
            conditionCodeByte[CC_LEVEL_HI:CC_LEVEL_LO] <= wb_dat_i[CC_LEVEL_HI:CC_LEVEL_LO];
        end
        if (aluGo) begin
            conditionCodeByte[CC_HALF_CARRY] <= aluFlags.half;
            conditionCodeByte[CC_NEGATIVE] <= aluFlags.negative;
            conditionCodeByte[CC_ZERO] <= aluFlags.zero;
            conditionCodeByte[CC_OVERFLOW] <= aluFlags.overflow;
            conditionCodeByte[CC_CARRY] <= aluFlags.carry;
        end else if (pswLowWrite) begin
            conditionCodeByte[CC_HALF_CARRY] <= wb_dat_i[CC_HALF_CARRY];
            conditionCodeByte[CC_NEGATIVE:CC_CARRY] <= wb_dat_i[CC_NEGATIVE:CC_CARRY];
        end
    end

    // Arithmetic command runs the cycle after the write is acked
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            aluGo <= 1'b0;
            aluOp <= ALU_ADD;
        end else begin
            aluGo <= busWrite & hitAlu & wb_sel_i[0];
            if (busWrite && hitAlu && wb_sel_i[0]) begin
                aluOp <= alu_op_e'(wb_dat_i[2:0]);
            end
        end
    end

    // Core-side outputs
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            irqAccept <= 1'b0;
            bankAddress <= MAP_REGISTER_BASE;
        end else begin
            irqAccept <= next_irqAccept;
            bankAddress <= next_bankAddress;
        end
    end

    // Checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    a_pc_reset_value: assert property (
        $fell(sys_rst) |-> (programCounter == RST_PROGRAM_COUNTER) || $past(instrFetch))
        else $error("program counter not FFFD after reset");

    a_mask_after_reset: assert property (
        $fell(sys_rst) |-> levelMask == 2'h3 && !conditionCodeByte[CC_INT_ENABLE])
        else $error("level mask or enable wrong after reset");

    a_irq_needs_enable: assert property (
        irqAccept |-> $past(conditionCodeByte[CC_INT_ENABLE]) && $past(irqIn.request))
        else $error("interrupt accepted while disabled");

    a_irq_level_gate: assert property (
        irqIn.request && conditionCodeByte[CC_INT_ENABLE]
        ##0 (irqIn.level >= levelMask) |=> !irqAccept)
        else $error("interrupt accepted at or below the mask level");

    a_zero_flag: assert property (
        aluGo |=> conditionCodeByte[CC_ZERO] == (accumulator[7:0] == 8'h00))
        else $error("zero flag disagrees with result");

    a_negative_flag: assert property (
        aluGo |=> conditionCodeByte[CC_NEGATIVE] == accumulator[7])
        else $error("negative flag disagrees with result msb");

    a_add_carry: assert property (
        aluGo && aluOp == ALU_ADD |=> conditionCodeByte[CC_CARRY]
            == (({1'b0, $past(lhs)} + {1'b0, $past(rhs)}) > 9'h0FF))
        else $error("carry wrong after add");

    a_shift_carry: assert property (
        aluGo && aluOp == ALU_SHR |=> conditionCodeByte[CC_CARRY] == $past(lhs[0]))
        else $error("carry is not the shifted-out bit");

    a_bank_address: assert property (
        busWrite && hitPsw && wb_sel_i[1] |=> ##1 bankAddress == MAP_REGISTER_BASE
            + 16'(REGS_PER_BANK * int'($past(wb_dat_i[8 +: BANK_BITS], 2))))
        else $error("bank address mismatch");

    a_ack_one_cycle: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    a_half_carry_add: assert property (
        aluGo && aluOp == ALU_ADD |=> conditionCodeByte[CC_HALF_CARRY]
            == (({1'b0, $past(lhs[3:0])} + {1'b0, $past(rhs[3:0])}) > 5'h0F))
        else $error("half carry wrong after add");

    a_sub_borrow: assert property (
        aluGo && aluOp == ALU_SUB |=> conditionCodeByte[CC_CARRY]
            == ($past(lhs) < $past(rhs)))
        else $error("borrow wrong after subtract");

    a_add_overflow: assert property (
        aluGo && aluOp == ALU_ADD |=> conditionCodeByte[CC_OVERFLOW]
            == (($past(lhs[7]) == $past(rhs[7])) && (accumulator[7] != $past(lhs[7]))))
        else $error("overflow wrong after add");

    a_shl_carry: assert property (
        aluGo && aluOp == ALU_SHL |=> conditionCodeByte[CC_CARRY] == $past(lhs[7]))
        else $error("carry is not the bit shifted out left");

    a_acc_high_kept: assert property (
        aluGo |=> accumulator[15:8] == $past(accumulator[15:8]))
        else $error("8-bit operation changed the accumulator high byte");

    a_shift_keeps_half: assert property (
        aluGo && (aluOp == ALU_SHL || aluOp == ALU_SHR) |=> conditionCodeByte[CC_HALF_CARRY]
            == $past(conditionCodeByte[CC_HALF_CARRY]))
        else $error("shift changed the half carry");

    a_irq_blocked: assert property (
        !conditionCodeByte[CC_INT_ENABLE] |=> !irqAccept)
        else $error("interrupt accepted with enable clear");

endmodule : cpu_register_set

`default_nettype wire

// file: sim/cpu_register_set_and_flags_bench.sv
`timescale 1ns/1ps
`default_nettype none

module cpu_register_set_and_flags_bench;
    import cpu_regs_pkg::*;

    localparam int BANKS = 8;
    logic clock = 1'b0;
    logic sysRst = 1'b1;
    logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
    logic [7:0] wbAdr = 8'h00;
    logic [3:0] wbSel = 4'h0;
    logic [31:0] wbDatW = 32'h0, wbDatR, rd;
    logic wbAck, instrFetch = 1'b0, irqAccept;
    irq_req_s irqIn = '0;
    logic [15:0] bankAddress;
    int err_count = 0;
    int check_count = 0;

    always #12.5 clock = ~clock;

    cpu_register_set #(.BANK_COUNT(BANKS)) dut (
        .clock(clock), .sys_rst(sysRst),
        .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
        .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck),
        .instrFetch(instrFetch), .irqIn(irqIn), .irqAccept(irqAccept),
        .bankAddress(bankAddress)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] din);
        int n;
        @(posedge clock);
        wbCyc <= 1'b1; wbStb <= 1'b1; wbWe <= we; wbAdr <= adr; wbDatW <= din; wbSel <= 4'hF;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (wbAck !== 1'b1 && n < 50);
        if (n >= 50) check(32'h0, 32'h1, "ack timeout");
        rd = wbDatR;
        wbCyc <= 1'b0; wbStb <= 1'b0; wbWe <= 1'b0;
    endtask : wb_xfer

    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp, input string msg);
        wb_xfer(1'b0, adr, 32'h0);
        check(rd, exp, msg);
    endtask : rd_chk

    task automatic do_reset;
        @(posedge clock);
        sysRst <= 1'b1;
        repeat (6) @(posedge clock);
        check({31'h0, wbAck}, 32'h0, "ack in reset");
        sysRst <= 1'b0;
    endtask : do_reset

    task automatic test_reset;
        wb_xfer(1'b1, OFS_PROGRAM_COUNTER, 32'h1111);
        wb_xfer(1'b1, OFS_PROGRAM_STATUS_WORD, 32'h0040);
        do_reset();
        rd_chk(OFS_PROGRAM_COUNTER, 32'hFFFD, "pc reset");
        wb_xfer(1'b0, OFS_PROGRAM_STATUS_WORD, 32'h0);
        check({29'h0, rd[6:4]}, 32'h3, "int enable and mask reset");
        $display("test reset done");
    endtask : test_reset

    task automatic test_regs;
        logic [7:0] ofs [5] = '{OFS_ACCUMULATOR, OFS_TEMPORARY_ACCUMULATOR, OFS_INDEX_POINTER,
                                OFS_EXTRA_POINTER, OFS_STACK_POINTER};
        for (int i = 0; i < 5; i++) begin
            wb_xfer(1'b1, ofs[i], 32'hFFFF_A5C3 ^ 32'(i * 16'h1111));
            rd_chk(ofs[i], 32'h0000_A5C3 ^ 32'(i * 16'h1111), "reg rw");
        end
        wb_xfer(1'b1, 8'h30, 32'h1234);
        rd_chk(8'h30, 32'h0, "unmapped");
        $display("test regs done");
    endtask : test_regs

    task automatic test_fetch;
        wb_xfer(1'b1, OFS_PROGRAM_COUNTER, 32'h1234);
        @(posedge clock);
        instrFetch <= 1'b1;
        repeat (3) @(posedge clock);
        instrFetch <= 1'b0;
        rd_chk(OFS_PROGRAM_COUNTER, 32'h1237, "pc advance");
        $display("test fetch done");
    endtask : test_fetch

    task automatic test_region;
        logic [15:0] pc [8] = '{16'h0000, 16'h007F, 16'h0080, 16'hBFFF, 16'hC000, 16'hFFBF,
                                16'hFFC0, 16'hFFFF};
        logic [1:0] expRegion [8] = '{REGION_IO, REGION_IO, REGION_DATA, REGION_DATA, REGION_PROGRAM,
                                  REGION_PROGRAM, REGION_VECTOR, REGION_VECTOR};
        for (int i = 0; i < 8; i++) begin
            wb_xfer(1'b1, OFS_PROGRAM_COUNTER, {16'h0, pc[i]});
            wb_xfer(1'b0, OFS_CORE_STATUS, 32'h0);
            check({30'h0, rd[1:0]}, {30'h0, expRegion[i]}, "region");
        end
        $display("test region done");
    endtask : test_region

    function automatic logic [12:0] alu_ref(input alu_op_e op, input logic [7:0] a, b, cc);
        logic [8:0] s;
        logic h, v, c, ci;
        ci = cc[0] & (op == ALU_ADDC || op == ALU_SUBC);
        h = cc[7];
        v = cc[1];
        case (op)
            ALU_ADD, ALU_ADDC: begin
                s = {1'b0, a} + {1'b0, b} + 9'(ci);
                h = ({1'b0, a[3:0]} + {1'b0, b[3:0]} + 5'(ci)) > 5'h0F;
                v = (a[7] == b[7]) && (s[7] != a[7]);
                c = s[8];
            end
            ALU_SUB, ALU_SUBC: begin
                s = {1'b0, a} - {1'b0, b} - 9'(ci);
                h = {1'b0, a[3:0]} < ({1'b0, b[3:0]} + 5'(ci));
                v = (a[7] != b[7]) && (s[7] != a[7]);
                c = s[8];
            end
            ALU_SHL: begin
                s = {1'b0, a[6:0], cc[0]};
                c = a[7];
            end
            default: begin
                s = {1'b0, cc[0], a[7:1]};
                c = a[0];
            end
        endcase
        return {s[7:0], h, s[7], s[7:0] == 8'h00, v, c};
    endfunction : alu_ref

    task automatic alu_case(input alu_op_e op, input logic [7:0] a, b, cc);
        logic [12:0] e;
        e = alu_ref(op, a, b, cc);
        wb_xfer(1'b1, OFS_ACCUMULATOR, {16'h0, 8'h5A, a});
        wb_xfer(1'b1, OFS_TEMPORARY_ACCUMULATOR, {16'h0, 8'hC3, b});
        wb_xfer(1'b1, OFS_PROGRAM_STATUS_WORD, {24'h0, cc});
        wb_xfer(1'b1, OFS_ALU_COMMAND, {29'h0, op});
        rd_chk(OFS_ALU_COMMAND, {29'h0, op}, "alu command readback");
        rd_chk(OFS_ACCUMULATOR, {16'h0, 8'h5A, e[12:5]}, "alu result");
        wb_xfer(1'b0, OFS_PROGRAM_STATUS_WORD, 32'h0);
        check({24'h0, rd[7:0]}, {24'h0, e[4], cc[6:4], e[3:0]}, "alu flags");
    endtask : alu_case

    task automatic test_alu;
        alu_case(ALU_ADD, 8'h0F, 8'h01, 8'h30);
        alu_case(ALU_ADD, 8'h7F, 8'h01, 8'h30);
        alu_case(ALU_ADD, 8'hFF, 8'h01, 8'h30);
        alu_case(ALU_SUB, 8'h00, 8'h01, 8'h30);
        alu_case(ALU_SUB, 8'h80, 8'h01, 8'h30);
        alu_case(ALU_ADDC, 8'h01, 8'h01, 8'h31);
        alu_case(ALU_SUBC, 8'h05, 8'h01, 8'h31);
        alu_case(ALU_SHL, 8'h81, 8'h00, 8'hB2);
        alu_case(ALU_SHR, 8'h01, 8'h00, 8'hB2);
        $display("test alu done");
    endtask : test_alu

    task automatic test_irq;
        for (int m = 0; m < 4; m++)
            for (int l = 0; l < 4; l++)
                for (int en = 0; en < 2; en++) begin
                    wb_xfer(1'b1, OFS_PROGRAM_STATUS_WORD, {25'h0, en[0], m[1:0], 4'h0});
                    @(posedge clock);
                    irqIn <= '{request: (l != 3 || m != 3) ? 1'b1 : 1'b0, level: l[1:0]};
                    repeat (3) @(posedge clock);
                    check({31'h0, irqAccept}, {31'h0, en[0] && (l < m) && (l != 3 || m != 3)},
                          "irq accept");
                end
        $display("test irq done");
    endtask : test_irq

    task automatic test_bank;
        logic [7:0] bp [6] = '{8'h00, 8'h01, 8'h07, 8'h08, 8'h1F, 8'hFF};
        logic [15:0] exp;
        for (int i = 0; i < 6; i++) begin
            exp = MAP_REGISTER_BASE + 16'(REGS_PER_BANK * (bp[i] % BANKS));
            wb_xfer(1'b1, OFS_PROGRAM_STATUS_WORD, {16'h0, bp[i], 8'h30});
            rd_chk(OFS_BANK_ADDRESS, {16'h0, exp}, "bank address reg");
            check({16'h0, bankAddress}, {16'h0, exp}, "bank address port");
        end
        $display("test bank done");
    endtask : test_bank

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up

    initial begin
        repeat (6) @(posedge clock);
        sysRst <= 1'b0;
        test_reset();
        test_regs();
        test_fetch();
        test_region();
        test_alu();
        test_irq();
        test_bank();
        wrap_up();
    end

    // Full run needs about 600 cycles; 20000-cycle limit is a generous margin
    initial begin
        #(25 * 20000);
        err_count++;
        wrap_up();
    end

endmodule : cpu_register_set_and_flags_bench

`default_nettype wire
